// File: pkg/fire_pkg.sv
// Package: register map, fields, reset values and timing for the override block
`default_nettype none
package fire_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SPEED = 8'h04;
    localparam logic [7:0] OFF_FBLOSS = 8'h08;
    localparam logic [7:0] OFF_AILOSS = 8'h0C;
    localparam logic [7:0] OFF_PASS = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ = 8'h18;
    localparam logic [7:0] OFF_MASK = 8'h1C;
    localparam logic [7:0] OFF_MAXF = 8'h20;
    // CTRL fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_POL = 1;
    localparam int CTRL_SRC = 2;
    localparam int CTRL_DIR = 4;
    // Loss register fields: level [6:0], delay [14:8], fallback [17:16]
    localparam int LOSS_DLY = 8;
    localparam int LOSS_SEL = 16;
    localparam logic [6:0] LEVEL_MAX = 7'd100;
    localparam logic [6:0] DELAY_MAX = 7'd100;
    localparam logic [13:0] SPEED_MAX = 14'd10000;
    localparam logic [15:0] PASS_NONE = 16'hFFFF;
    localparam logic [15:0] MAXF_RESET = 16'h1770;
    // Speed sources and fallbacks
    localparam logic [1:0] SRC_FIXED = 2'd0;
    localparam logic [1:0] SRC_PID = 2'd1;
    localparam logic [1:0] SRC_AIN = 2'd2;
    localparam logic [1:0] FB_HOLD = 2'd0;
    localparam logic [1:0] FB_SPEED = 2'd1;
    localparam logic [1:0] FB_MAX = 2'd2;
    // Interrupt bits
    localparam int IRQ_ENTER = 0;
    localparam int IRQ_FBLOSS = 1;
    localparam int IRQ_AILOSS = 2;
    localparam int IRQ_WBLOCK = 3;
    // Timing: 100 ms delay tick, 360 ms comparison window
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 100;
    localparam int WIN_MS = 360;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int WIN_CYC = CLK_HZ / 1000 * WIN_MS;
endpackage : fire_pkg
`default_nettype wire

// File: src/fire_mode_speed_supervisor.sv
// Emergency override supervisor: forces run, speed and direction, loss watch
// Functional notes
// R01: Override keeps running, ignores software trips
// R02: Polarity bit: 0 normally open, 1 closed
// R03: Operator disables override before changing polarity
// R04: Source 0: fixed percent of max frequency
// R05: Source 1: PID with override PID set
// R06: Source 2: second analog input reference
// R07: Direction from override setting while active
// R08: Override settings read-only while active
// R09: Only one password set at a time
// R10: Feedback loss level 0-100, delay 0-10s
// R11: PID source enables feedback loss watch
// R12: Feedback fallback: hold, override speed, maximum
// R13: On loss keep running, floor override speed
// R14: Level zero never triggers feedback loss
// R15: Analog loss level 0-100, delay 0-10s
// R16: Analog source enables analog loss watch
// R17: Analog fallback: hold, override speed, maximum
// R18: Analog compared with value 360ms earlier
// R19: Feedback loss never stops the drive
`default_nettype none
module fire_mode_speed_supervisor #(
    parameter int TICK_CYCLES = fire_pkg::TICK_CYC,
    parameter int WIN_CYCLES = fire_pkg::WIN_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic override_trigger_input,
    input wire logic [15:0] second_analog_input,
    input wire logic [15:0] pid_feedback,
    input wire logic [15:0] pid_freq,
    input wire logic [15:0] normal_freq,
    input wire logic normal_run,
    input wire logic normal_dir,
    input wire logic soft_trip,
    input wire logic hard_trip,
    input wire logic general_pass_set,
    output logic [15:0] freq_ref,
    output logic run_cmd,
    output logic dir_cmd,
    output logic override_active,
    output logic pid_set_sel,
    output logic keypad_override_view,
    output logic fb_lost,
    output logic ai_lost,
    output logic irq
);
    import fire_pkg::*;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_LOSS = 3'b100
    } mode_t;

    // Percent (0..100 or 0..10000 hundredths) scaled to max frequency
    function automatic logic [15:0] scale(input logic [15:0] maxf,
                                          input logic [13:0] hund);
        logic [29:0] p;
        p = 30'(maxf) * 30'(hund);
        scale = 16'(p / 30'd10000);
    endfunction : scale

    function automatic logic [15:0] pick(input logic [1:0] sel,
                                         input logic [15:0] hold,
                                         input logic [15:0] spd,
                                         input logic [15:0] maxf);
        if (sel == FB_SPEED) pick = spd;
        else if (sel == FB_MAX) pick = maxf;
        else pick = hold;
    endfunction : pick

    logic [4:0] ctrl_reg;
    logic [13:0] speed_reg;
    logic [17:0] fb_reg;
    logic [17:0] ai_reg;
    logic [15:0] pass_reg;
    logic [15:0] maxf_reg;
    logic [3:0] irq_reg;
    logic [3:0] mask_reg;
    logic trig_s1, trig_s2;
    logic [15:0] ain_s1, ain_s2, fbk_s1, fbk_s2;
    mode_t mode_reg;
    logic [31:0] tick_cnt, win_cnt;
    logic [6:0] fb_dly, ai_dly;
    logic fb_lost_reg, ai_lost_reg;
    logic [15:0] ai_prev, hold_reg;
    logic [15:0] freq_reg;
    logic run_reg, dir_reg;
    logic [7:0] a_reg;
    logic w_reg, v_reg;

    // Bus address phase capture
    wire take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_reg <= 8'h00;
            w_reg <= 1'b0;
            v_reg <= 1'b0;
        end else begin
            a_reg <= take ? haddr[7:0] : a_reg;
            w_reg <= take && hwrite;
            v_reg <= take;
        end
    end

    wire active = mode_reg != ST_NORMAL;
    wire wr = v_reg && w_reg;
    wire wr_ctrl = wr && a_reg == OFF_CTRL;
    wire wr_cfg = wr && (a_reg == OFF_CTRL || a_reg == OFF_SPEED ||
                         a_reg == OFF_FBLOSS || a_reg == OFF_AILOSS ||
                         a_reg == OFF_PASS);
    wire locked = active && wr_cfg && !(a_reg == OFF_CTRL); // [R08]
    wire ctrl_lock = active && wr_ctrl; // [R08]
    wire [1:0] src = ctrl_reg[CTRL_SRC +: 2];
    wire pass_ok = !general_pass_set || hwdata[15:0] == PASS_NONE; // [R09]
    wire [6:0] lvl_fb = hwdata[6:0] > LEVEL_MAX ? LEVEL_MAX : hwdata[6:0];
    wire [6:0] dly_w = hwdata[LOSS_DLY +: 7] > DELAY_MAX ? DELAY_MAX
                     : hwdata[LOSS_DLY +: 7];
    wire [17:0] loss_w = {hwdata[LOSS_SEL +: 2], 1'b0, dly_w, 1'b0, lvl_fb};
    wire [13:0] spd_w = hwdata[13:0] > SPEED_MAX ? SPEED_MAX : hwdata[13:0];
    wire blocked = locked || ctrl_lock ||
                   (wr && a_reg == OFF_PASS && !pass_ok);

    // Settings registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= 5'h00;
            speed_reg <= 14'h0000;
            fb_reg <= 18'h00000;
            ai_reg <= 18'h00000;
            pass_reg <= PASS_NONE;
            maxf_reg <= MAXF_RESET;
            mask_reg <= 4'h0;
        end else if (wr && !blocked) begin
            if (a_reg == OFF_CTRL) ctrl_reg <= hwdata[4:0];
            else if (a_reg == OFF_SPEED) speed_reg <= spd_w;
            else if (a_reg == OFF_FBLOSS) fb_reg <= loss_w; // [R10]
            else if (a_reg == OFF_AILOSS) ai_reg <= loss_w; // [R15]
            else if (a_reg == OFF_PASS) pass_reg <= hwdata[15:0]; // [R09]
            else if (a_reg == OFF_MAXF) maxf_reg <= hwdata[15:0];
            else if (a_reg == OFF_MASK) mask_reg <= hwdata[3:0];
        end
    end

    // Trigger and analog inputs synchronised
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            ain_s1 <= 16'h0000;
            ain_s2 <= 16'h0000;
            fbk_s1 <= 16'h0000;
            fbk_s2 <= 16'h0000;
        end else begin
            trig_s1 <= override_trigger_input;
            trig_s2 <= trig_s1;
            ain_s1 <= second_analog_input;
            ain_s2 <= ain_s1;
            fbk_s1 <= pid_feedback;
            fbk_s2 <= fbk_s1;
        end
    end

    wire trig = trig_s2 ^ ctrl_reg[CTRL_POL]; // [R02]
    wire want = ctrl_reg[CTRL_EN] && trig;
    wire tick = tick_cnt == 32'(TICK_CYCLES - 1);
    wire win = win_cnt == 32'(WIN_CYCLES - 1);
    wire [15:0] lvl_fb_v = scale(16'hFFFF, 14'(fb_reg[6:0]) * 14'd100);
    wire [15:0] lvl_ai_v = scale(16'hFFFF, 14'(ai_reg[6:0]) * 14'd100);
    wire fb_watch = active && src == SRC_PID; // [R11]
    wire ai_watch = active && src == SRC_AIN; // [R16]
    wire fb_low = fb_watch && fb_reg[6:0] != 7'd0 && fbk_s2 < lvl_fb_v; // [R14]
    wire ai_low = ai_watch && (ai_s2_lt(ain_s2, ai_prev, lvl_ai_v)); // [R18]

    function automatic logic ai_s2_lt(input logic [15:0] now,
                                      input logic [15:0] prev,
                                      input logic [15:0] lvl);
        ai_s2_lt = now < lvl && now < prev;
    endfunction : ai_s2_lt

    wire [15:0] spd_f = scale(maxf_reg, speed_reg); // [R04]
    wire fb_fire = fb_low && tick && fb_dly >= fb_reg[LOSS_DLY +: 7];
    wire ai_fire = ai_low && tick && ai_dly >= ai_reg[LOSS_DLY +: 7];

    // Mode, timers and loss detectors
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= ST_NORMAL;
            tick_cnt <= 32'd0;
            win_cnt <= 32'd0;
            fb_dly <= 7'd0;
            ai_dly <= 7'd0;
            fb_lost_reg <= 1'b0;
            ai_lost_reg <= 1'b0;
            ai_prev <= 16'h0000;
            hold_reg <= 16'h0000;
        end else begin
            tick_cnt <= tick ? 32'd0 : tick_cnt + 32'd1;
            win_cnt <= win ? 32'd0 : win_cnt + 32'd1;
            // Reference sample frozen while low so the delay can run out
            if (win && !ai_low) ai_prev <= ain_s2; // [R18]
            if (!fb_low) fb_dly <= 7'd0;
            else if (tick && fb_dly != 7'h7F) fb_dly <= fb_dly + 7'd1;
            if (!ai_low) ai_dly <= 7'd0;
            else if (tick && ai_dly != 7'h7F) ai_dly <= ai_dly + 7'd1;
            case (mode_reg)
                ST_NORMAL: begin
                    fb_lost_reg <= 1'b0;
                    ai_lost_reg <= 1'b0;
                    if (want) mode_reg <= ST_ACTIVE;
                end
                ST_ACTIVE: begin
                    hold_reg <= freq_reg;
                    if (!want) mode_reg <= ST_NORMAL;
                    else if (fb_fire || ai_fire) begin
                        fb_lost_reg <= fb_fire; // [R13]
                        ai_lost_reg <= ai_fire;
                        mode_reg <= ST_LOSS; // [R19]
                    end
                end
                ST_LOSS: begin
                    if (!want) mode_reg <= ST_NORMAL;
                end
                default: mode_reg <= ST_NORMAL;
            endcase
        end
    end

    // Speed selection
    wire [15:0] base_f = src == SRC_PID ? pid_freq // [R05]
                       : src == SRC_AIN ? scale(maxf_reg, // [R06]
                             14'((30'(ain_s2) * 30'd10000) / 30'hFFFF))
                       : spd_f;
    wire [1:0] fsel = fb_lost_reg ? fb_reg[LOSS_SEL +: 2] // [R12]
                                  : ai_reg[LOSS_SEL +: 2]; // [R17]
    wire [15:0] fall_f = pick(fsel, hold_reg, spd_f, maxf_reg);
    wire [15:0] loss_f = fall_f < spd_f ? spd_f : fall_f; // [R13]
    wire [15:0] ovr_f = mode_reg == ST_LOSS ? loss_f : base_f;

    // Drive outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_reg <= 16'h0000;
            run_reg <= 1'b0;
            dir_reg <= 1'b0;
        end else begin
            freq_reg <= active ? ovr_f : normal_freq;
            // Only hard trips stop the drive while overriding
            run_reg <= active ? !hard_trip // [R01]
                              : normal_run && !soft_trip && !hard_trip;
            dir_reg <= active ? ctrl_reg[CTRL_DIR] : normal_dir; // [R07]
        end
    end

    // Sticky events, set wins over write-one clear
    wire [3:0] ev = {blocked, ai_fire && mode_reg == ST_ACTIVE,
                     fb_fire && mode_reg == ST_ACTIVE,
                     want && mode_reg == ST_NORMAL};
    wire [3:0] clr = (wr && a_reg == OFF_IRQ) ? hwdata[3:0] : 4'h0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) irq_reg <= 4'h0;
        else irq_reg <= (irq_reg & ~clr) | ev;
    end

    wire [31:0] status_w = {27'd0, ai_lost_reg, fb_lost_reg,
                            mode_reg == ST_LOSS, trig, active};
    wire [31:0] rd_w =
        a_reg == OFF_CTRL ? {27'd0, ctrl_reg} :
        a_reg == OFF_SPEED ? {18'd0, speed_reg} :
        a_reg == OFF_FBLOSS ? {14'd0, fb_reg} :
        a_reg == OFF_AILOSS ? {14'd0, ai_reg} :
        a_reg == OFF_PASS ? {16'd0, pass_reg} :
        a_reg == OFF_STATUS ? status_w :
        a_reg == OFF_IRQ ? {28'd0, irq_reg} :
        a_reg == OFF_MASK ? {28'd0, mask_reg} :
        a_reg == OFF_MAXF ? {16'd0, maxf_reg} : 32'h0000_0000;

    assign hrdata = (v_reg && !w_reg) ? rd_w : 32'h0000_0000;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign freq_ref = freq_reg;
    assign run_cmd = run_reg;
    assign dir_cmd = dir_reg;
    assign override_active = active;
    assign pid_set_sel = active && src == SRC_PID; // [R05]
    assign keypad_override_view = active; // [R08]
    assign fb_lost = fb_lost_reg;
    assign ai_lost = ai_lost_reg;
    assign irq = |(irq_reg & mask_reg);
endmodule : fire_mode_speed_supervisor
`default_nettype wire

// File: dv/fire_checker.sv
// Checker: bus answer and override output relations of the supervisor
`default_nettype none
module fire_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [15:0] normal_freq,
    input wire logic hard_trip,
    input wire logic [15:0] freq_ref,
    input wire logic run_cmd,
    input wire logic override_active,
    input wire logic pid_set_sel,
    input wire logic keypad_override_view,
    input wire logic fb_lost,
    input wire logic ai_lost
);
    logic xfer_ph;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) xfer_ph <= 1'b0;
        else xfer_ph <= hsel && hready && htrans[1];
    end
    sequence s_rd_unmapped;
        hsel && hready && htrans[1] && !hwrite && haddr > 32'h20;
    endsequence
    sequence s_active_free;
        override_active && !hard_trip;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_idle_rdata: assert property (!xfer_ph |-> hrdata == 32'h0)
        else $error("read data outside a data phase");
    a_unmapped_zero: assert property (s_rd_unmapped |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_run_forced: assert property (s_active_free |=> run_cmd)
        else $error("override stopped the drive");
    a_hard_stop: assert property (override_active && hard_trip |=> !run_cmd)
        else $error("hardware trip did not stop the drive");
    a_keypad_view: assert property (keypad_override_view == override_active)
        else $error("keypad view differs from override state");
    a_pid_set: assert property (pid_set_sel |-> override_active)
        else $error("override PID set used outside override");
    a_loss_clears: assert property ($fell(override_active) |=> !fb_lost && !ai_lost)
        else $error("loss flag kept after override exit");
    a_normal_ref: assert property (!override_active |=> freq_ref == $past(normal_freq))
        else $error("normal reference not passed through");
endmodule : fire_checker
bind fire_mode_speed_supervisor fire_checker u_chk (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
    .normal_freq, .hard_trip, .freq_ref, .run_cmd, .override_active,
    .pid_set_sel, .keypad_override_view, .fb_lost, .ai_lost);
`default_nettype wire

// File: dv/drive_core_model.sv
// Partner model: drive core that supplies PID and normal commands
`default_nettype none
module drive_core_model #(
    parameter logic [15:0] PID_REF = 16'h1000,
    parameter logic [15:0] NORMAL_REF = 16'h0400
) (
    input wire logic hresetn,
    output logic [15:0] pid_freq,
    output logic [15:0] normal_freq,
    output logic normal_run,
    output logic normal_dir
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pid_freq = PID_REF;
    assign normal_freq = NORMAL_REF;
    assign normal_run = hresetn;
    assign normal_dir = 1'b0;
endmodule : drive_core_model
`default_nettype wire

// File: dv/testbench.sv
// Testbench: register, override, loss and interrupt scenarios
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fire_pkg::*;
    localparam logic [15:0] PID_REF = 16'h1000;
    localparam logic [15:0] SPD_F = 16'(32'(MAXF_RESET) * 5000 / 10000);
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd_v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic override_trigger_input, soft_trip, hard_trip, general_pass_set;
    logic [15:0] second_analog_input, pid_feedback, pid_freq, normal_freq;
    logic [15:0] freq_ref;
    logic normal_run, normal_dir, run_cmd, dir_cmd, override_active, irq;
    logic pid_set_sel, keypad_override_view, fb_lost, ai_lost;
    int err_count, checks;
    logic [7:0] offs [8] = '{OFF_CTRL, OFF_SPEED, OFF_FBLOSS, OFF_AILOSS,
        OFF_PASS, OFF_MASK, OFF_MAXF, 8'h24};
    logic [31:0] rstv [8] = '{0, 0, 0, 0, 32'h0000FFFF, 0, 32'h00001770, 0};
    drive_core_model #(.PID_REF(PID_REF)) partner (.hresetn, .pid_freq,
        .normal_freq, .normal_run, .normal_dir);
    fire_mode_speed_supervisor #(.TICK_CYCLES(10), .WIN_CYCLES(36)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .override_trigger_input,
        .second_analog_input, .pid_feedback, .pid_freq, .normal_freq,
        .normal_run, .normal_dir, .soft_trip, .hard_trip, .general_pass_set,
        .freq_ref, .run_cmd, .dir_cmd, .override_active, .pid_set_sel,
        .keypad_override_view, .fb_lost, .ai_lost, .irq);
    assign hready = hreadyout;
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wait_rdy();
        logic rdy;
        for (int n = 0; n < 20; n++) begin
            @(negedge hclk);
            rdy = hreadyout;
            rd_v = hrdata;
            @(posedge hclk);
            if (rdy === 1'b1) break;
        end
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
    endtask : bus
    task automatic wait_active(input logic v);
        for (int i = 0; i < 50 && override_active !== v; i++) @(posedge hclk);
        repeat (3) @(posedge hclk);
        chk("override state", override_active, v);
    endtask : wait_active
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        #100us;
        err_count++;
        tally_and_finish();
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
        hsize = 3'b010;
        {override_trigger_input, soft_trip, hard_trip, general_pass_set} = '0;
        {second_analog_input, pid_feedback} = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        @(posedge hclk);
        foreach (offs[i]) begin
            bus(1'b0, offs[i], 32'h0);
            chk("reset value", rd_v, rstv[i]);
        end
        foreach (offs[i]) if (i == 2 || i == 3) begin
            bus(1'b1, offs[i], 32'h00027F7F);
            bus(1'b0, offs[i], 32'h0);
            chk("loss clamp", rd_v, 32'h00026464);
        end
        general_pass_set <= 1'b1;
        bus(1'b1, OFF_PASS, 32'h00001234);
        bus(1'b0, OFF_PASS, 32'h0);
        chk("password", rd_v, {16'h0, PASS_NONE});
        general_pass_set <= 1'b0;
        $display("test registers done");
        bus(1'b1, OFF_SPEED, 32'd5000);
        bus(1'b1, OFF_MASK, 32'h9);
        bus(1'b1, OFF_CTRL, 32'h11);
        soft_trip <= 1'b1;
        override_trigger_input <= 1'b1;
        wait_active(1'b1);
        chk("run", run_cmd, 1);
        chk("direction", dir_cmd, 1);
        chk("fixed speed", freq_ref, SPD_F);
        chk("keypad", keypad_override_view, 1);
        chk("irq raised", irq, 1);
        hard_trip <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("hard stop", run_cmd, 0);
        {hard_trip, soft_trip} <= 2'b00;
        bus(1'b1, OFF_SPEED, 32'h0);
        bus(1'b0, OFF_SPEED, 32'h0);
        chk("locked speed", rd_v, 32'd5000);
        bus(1'b0, OFF_IRQ, 32'h0);
        chk("irq status", rd_v, 32'h9);
        bus(1'b1, OFF_IRQ, 32'h9);
        repeat (2) @(posedge hclk);
        chk("irq cleared", irq, 0);
        override_trigger_input <= 1'b0;
        wait_active(1'b0);
        $display("test override done");
        bus(1'b1, OFF_FBLOSS, 32'h00020200);
        bus(1'b1, OFF_CTRL, 32'h7);
        wait_active(1'b1);
        chk("pid set", pid_set_sel, 1);
        chk("pid speed", freq_ref, PID_REF);
        repeat (100) @(posedge hclk);
        chk("level zero", fb_lost, 0);
        override_trigger_input <= 1'b1;
        wait_active(1'b0);
        bus(1'b1, OFF_FBLOSS, 32'h00020232);
        override_trigger_input <= 1'b0;
        wait_active(1'b1);
        chk("early loss", fb_lost, 0);
        bus(1'b1, OFF_IRQ, 32'h1);
        for (int i = 0; i < 200 && fb_lost !== 1'b1; i++) @(posedge hclk);
        chk("feedback lost", fb_lost, 1);
        repeat (2) @(posedge hclk);
        chk("fallback max", freq_ref, MAXF_RESET);
        chk("keeps running", run_cmd, 1);
        chk("irq masked", irq, 0);
        bus(1'b0, OFF_IRQ, 32'h0);
        chk("loss event", rd_v[1], 1);
        override_trigger_input <= 1'b1;
        wait_active(1'b0);
        $display("test feedback loss done");
        second_analog_input <= 16'hFFFF;
        bus(1'b1, OFF_AILOSS, 32'h00010132);
        bus(1'b1, OFF_CTRL, 32'hB);
        override_trigger_input <= 1'b0;
        wait_active(1'b1);
        repeat (80) @(posedge hclk);
        chk("analog speed", freq_ref >= MAXF_RESET - 16'h1, 1);
        chk("no analog loss", ai_lost, 0);
        second_analog_input <= 16'h0000;
        for (int i = 0; i < 300 && ai_lost !== 1'b1; i++) @(posedge hclk);
        chk("analog lost", ai_lost, 1);
        repeat (2) @(posedge hclk);
        chk("fallback speed", freq_ref, SPD_F);
        $display("test analog loss done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
